/* File: src/pil_irq_top.sv */
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
module pil_irq_top
	import pil_pkg::*;
(
	input  wire logic        REF_CLK,
	input  wire logic        RST_B,
	input  wire logic [31:0] ADDR,
	input  wire logic [31:0] WR_DATA,
	input  wire logic        WR_STB,
	input  wire logic        RD_STB,
	output logic      [31:0] RD_DATA,
	input  wire logic [3:0]  KEY_IN,
	input  wire logic [31:0] EXP1_IN,
	input  wire logic [31:0] EXP2_IN,
	input  wire logic        TMR0_TIMEOUT,
	input  wire logic        TMR0_RUN,
	input  wire logic        TMR1_TIMEOUT,
	input  wire logic        TMR1_RUN,
	input  wire logic [15:0] RX_CHAR_COUNT,
	input  wire logic [7:0]  RX_CHAR,
	input  wire logic [15:0] TX_FREE_COUNT,
	output logic             RX_POP,
	output logic             TX_PUSH,
	output logic      [7:0]  TX_CHAR,
	input  wire logic        AUDIO_IRQ,
	input  wire logic        KBD_IRQ,
	input  wire logic        IR_IRQ,
	input  wire logic        UART_IRQ,
	input  wire logic        KBD2_IRQ,
	output logic      [31:0] IRQ,
	output logic      [31:0] RESET_VECTOR,
	output logic      [31:0] EXC_VECTOR
);

	// ----------------------------------------------------------------
	// Request decode
	// ----------------------------------------------------------------
	pil_req_t req;
	assign req = '{addr: ADDR, wdata: WR_DATA, wr: WR_STB, rd: RD_STB};

	// Address match helper
	function automatic logic hit(input logic [31:0] a, input logic [31:0] base,
		input logic [31:0] ofs);
		hit = (a == base + ofs);
	endfunction : hit

	logic wr_key_mask;
	logic wr_key_edge;
	logic wr_e1_mask;
	logic wr_e1_edge;
	logic wr_e2_mask;
	logic wr_e2_edge;
	logic wr_t0_stat;
	logic wr_t0_ctrl;
	logic wr_t1_stat;
	logic wr_t1_ctrl;
	logic wr_ser_data;
	logic wr_ser_ctrl;
	logic rd_ser_data;

	// Write strobes per register, plus the serial data read strobe
	assign wr_key_mask = req.wr && hit(req.addr, KEY_BASE, PORT_MASK_OFS);
	assign wr_key_edge = req.wr && hit(req.addr, KEY_BASE, PORT_EDGE_OFS);
	assign wr_e1_mask  = req.wr && hit(req.addr, EXP1_BASE, PORT_MASK_OFS);
	assign wr_e1_edge  = req.wr && hit(req.addr, EXP1_BASE, PORT_EDGE_OFS);
	assign wr_e2_mask  = req.wr && hit(req.addr, EXP2_BASE, PORT_MASK_OFS);
	assign wr_e2_edge  = req.wr && hit(req.addr, EXP2_BASE, PORT_EDGE_OFS);
	assign wr_t0_stat  = req.wr && hit(req.addr, TMR0_BASE, TMR_STAT_OFS);
	assign wr_t0_ctrl  = req.wr && hit(req.addr, TMR0_BASE, TMR_CTRL_OFS);
	assign wr_t1_stat  = req.wr && hit(req.addr, TMR1_BASE, TMR_STAT_OFS);
	assign wr_t1_ctrl  = req.wr && hit(req.addr, TMR1_BASE, TMR_CTRL_OFS);
	assign wr_ser_data = req.wr && (req.addr == SER_DATA_ADDR);
	assign wr_ser_ctrl = req.wr && (req.addr == SER_CTRL_ADDR);
	assign rd_ser_data = req.rd && (req.addr == SER_DATA_ADDR);

	// ----------------------------------------------------------------
	// Parallel ports
	// ----------------------------------------------------------------
	logic [KEY_W-1:0] key_mask;
	logic [KEY_W-1:0] key_edge;
	logic [EXP_W-1:0] e1_mask;
	logic [EXP_W-1:0] e1_edge;
	logic [EXP_W-1:0] e2_mask;
	logic [EXP_W-1:0] e2_edge;
	logic             key_irq;
	logic             e1_irq;
	logic             e2_irq;

	// Pushbutton port
	pil_port_edge #(.N(KEY_W)) u_key (
		.clk     (REF_CLK),
		.rst_b   (RST_B),
		.pins    (KEY_IN),
		.wr_mask (wr_key_mask),
		.wr_edge (wr_key_edge),
		.wdata   (req.wdata[KEY_W-1:0]),
		.mask_r  (key_mask),
		.edge_r  (key_edge),
		.irq     (key_irq)
	);

	// First expansion port
	pil_port_edge #(.N(EXP_W)) u_exp1 (
		.clk     (REF_CLK),
		.rst_b   (RST_B),
		.pins    (EXP1_IN),
		.wr_mask (wr_e1_mask),
		.wr_edge (wr_e1_edge),
		.wdata   (req.wdata),
		.mask_r  (e1_mask),
		.edge_r  (e1_edge),
		.irq     (e1_irq)
	);

	// Second expansion port
	pil_port_edge #(.N(EXP_W)) u_exp2 (
		.clk     (REF_CLK),
		.rst_b   (RST_B),
		.pins    (EXP2_IN),
		.wr_mask (wr_e2_mask),
		.wr_edge (wr_e2_edge),
		.wdata   (req.wdata),
		.mask_r  (e2_mask),
		.edge_r  (e2_edge),
		.irq     (e2_irq)
	);

	// ----------------------------------------------------------------
	// Interval timers
	// ----------------------------------------------------------------
	logic t0_flag;
	logic t0_ien;
	logic t0_irq;
	logic t1_flag;
	logic t1_ien;
	logic t1_irq;

	// First timer
	pil_tmr_irq u_tmr0 (
		.clk       (REF_CLK),
		.rst_b     (RST_B),
		.timeout   (TMR0_TIMEOUT),
		.wr_stat   (wr_t0_stat),
		.wr_ctrl   (wr_t0_ctrl),
		.ien_wdata (req.wdata[TMO_IEN_BIT]),
		.flag_r    (t0_flag),
		.ien_r     (t0_ien),
		.irq       (t0_irq)
	);

	// Second timer
	pil_tmr_irq u_tmr1 (
		.clk       (REF_CLK),
		.rst_b     (RST_B),
		.timeout   (TMR1_TIMEOUT),
		.wr_stat   (wr_t1_stat),
		.wr_ctrl   (wr_t1_ctrl),
		.ien_wdata (req.wdata[TMO_IEN_BIT]),
		.flag_r    (t1_flag),
		.ien_r     (t1_ien),
		.irq       (t1_irq)
	);

	// ----------------------------------------------------------------
	// Serial channel thresholds
	// ----------------------------------------------------------------
	logic rx_irq_enable_r;
	logic tx_irq_enable_r;
	logic rx_irq_pending_r;
	logic tx_irq_pending_r;
	logic ser_irq;

	// Separate enables from control writes
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			rx_irq_enable_r <= 1'b0;
			tx_irq_enable_r <= 1'b0;
		end else if (wr_ser_ctrl) begin
			rx_irq_enable_r <= req.wdata[RX_EN_BIT];
			tx_irq_enable_r <= req.wdata[TX_EN_BIT];
		end
	end

	// Pending follows the counts; falls once data drains or fills
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			rx_irq_pending_r <= 1'b0;
			tx_irq_pending_r <= 1'b0;
		end else begin
			rx_irq_pending_r <= RX_CHAR_COUNT > SER_THRESH;
			tx_irq_pending_r <= TX_FREE_COUNT > SER_THRESH;
		end
	end

	assign ser_irq = (rx_irq_pending_r & rx_irq_enable_r)
		| (tx_irq_pending_r & tx_irq_enable_r);

	// Queue strobes to the serial datapath
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			RX_POP  <= 1'b0;
			TX_PUSH <= 1'b0;
			TX_CHAR <= 8'h00;
		end else begin
			RX_POP  <= rd_ser_data && (RX_CHAR_COUNT != 16'h0000);
			TX_PUSH <= wr_ser_data;
			if (wr_ser_data) TX_CHAR <= req.wdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Request lines and vectors
	// ----------------------------------------------------------------
	logic [31:0] irq_nxt;

	// Fixed line assignment
	always_comb begin
		irq_nxt            = REG_RST;
		irq_nxt[IRQ_TMR0]  = t0_irq;
		irq_nxt[IRQ_KEY]   = key_irq;
		irq_nxt[IRQ_TMR1]  = t1_irq;
		irq_nxt[IRQ_AUDIO] = AUDIO_IRQ;
		irq_nxt[IRQ_KBD]   = KBD_IRQ;
		irq_nxt[IRQ_SER]   = ser_irq;
		irq_nxt[IRQ_IR]    = IR_IRQ;
		irq_nxt[IRQ_UART]  = UART_IRQ;
		irq_nxt[IRQ_EXP1]  = e1_irq;
		irq_nxt[IRQ_EXP2]  = e2_irq;
		irq_nxt[IRQ_KBD2]  = KBD2_IRQ;
	end

	// Level request lines, registered
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) IRQ <= REG_RST;
		else IRQ <= irq_nxt;
	end

	// Vectors handed to the core
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			RESET_VECTOR <= RESET_ADDR;
			EXC_VECTOR   <= EXC_ADDR;
		end else begin
			RESET_VECTOR <= RESET_ADDR;
			EXC_VECTOR   <= EXC_ADDR;
		end
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	logic [31:0] rd_data_nxt;

	// Read data per address; unmapped reads zero
	always_comb begin
		rd_data_nxt = REG_RST;
		unique case (1'b1)
			hit(req.addr, KEY_BASE, PORT_DATA_OFS):  rd_data_nxt = 32'(KEY_IN);
			hit(req.addr, KEY_BASE, PORT_MASK_OFS):  rd_data_nxt = 32'(key_mask);
			hit(req.addr, KEY_BASE, PORT_EDGE_OFS):  rd_data_nxt = 32'(key_edge);
			hit(req.addr, EXP1_BASE, PORT_DATA_OFS): rd_data_nxt = EXP1_IN;
			hit(req.addr, EXP1_BASE, PORT_MASK_OFS): rd_data_nxt = e1_mask;
			hit(req.addr, EXP1_BASE, PORT_EDGE_OFS): rd_data_nxt = e1_edge;
			hit(req.addr, EXP2_BASE, PORT_DATA_OFS): rd_data_nxt = EXP2_IN;
			hit(req.addr, EXP2_BASE, PORT_MASK_OFS): rd_data_nxt = e2_mask;
			hit(req.addr, EXP2_BASE, PORT_EDGE_OFS): rd_data_nxt = e2_edge;
			(req.addr == SER_DATA_ADDR): begin
				rd_data_nxt[31:CNT_LSB] = RX_CHAR_COUNT;
				rd_data_nxt[RVALID_BIT] = RX_CHAR_COUNT != 16'h0000;
				rd_data_nxt[7:0]        = RX_CHAR;
			end
			(req.addr == SER_CTRL_ADDR): begin
				rd_data_nxt[31:CNT_LSB]   = TX_FREE_COUNT;
				rd_data_nxt[TX_PEND_BIT]  = tx_irq_pending_r;
				rd_data_nxt[RX_PEND_BIT]  = rx_irq_pending_r;
				rd_data_nxt[TX_EN_BIT]    = tx_irq_enable_r;
				rd_data_nxt[RX_EN_BIT]    = rx_irq_enable_r;
			end
			hit(req.addr, TMR0_BASE, TMR_STAT_OFS): begin
				rd_data_nxt[TMO_FLAG_BIT] = t0_flag;
				rd_data_nxt[RUN_BIT]      = TMR0_RUN;
			end
			hit(req.addr, TMR0_BASE, TMR_CTRL_OFS): rd_data_nxt[TMO_IEN_BIT] = t0_ien;
			hit(req.addr, TMR1_BASE, TMR_STAT_OFS): begin
				rd_data_nxt[TMO_FLAG_BIT] = t1_flag;
				rd_data_nxt[RUN_BIT]      = TMR1_RUN;
			end
			hit(req.addr, TMR1_BASE, TMR_CTRL_OFS): rd_data_nxt[TMO_IEN_BIT] = t1_ien;
			default: rd_data_nxt = REG_RST;
		endcase
	end

	// Read data stands one cycle after the strobe only
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) RD_DATA <= REG_RST;
		else if (req.rd) RD_DATA <= rd_data_nxt;
		else RD_DATA <= REG_RST;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_vector_fixed: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		##1 (RESET_VECTOR == 32'h0000_0000 && EXC_VECTOR == 32'h0000_0020))
		else $error("vector addresses wrong");
	a_key_line: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		key_irq |=> IRQ[1])
		else $error("key request not on line 1");
	a_timer_line: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		IRQ[0] == $past(t0_irq) && IRQ[2] == $past(t1_irq))
		else $error("timer request lines misrouted");
	a_exp_lines: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		IRQ[11] == $past(e1_irq) && IRQ[12] == $past(e2_irq) && IRQ[23] == $past(KBD2_IRQ))
		else $error("expansion or keyboard lines misrouted");
	a_rx_thresh: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		RX_CHAR_COUNT > 16'h0007 && rx_irq_enable_r && !wr_ser_ctrl |-> ##2 IRQ[8])
		else $error("receive threshold request missing");
	a_tx_drop: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		TX_FREE_COUNT <= 16'h0007 |=> !tx_irq_pending_r)
		else $error("transmit pending not cleared at threshold");
	a_key_clear: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		wr_key_edge && (KEY_IN & ~$past(KEY_IN)) == '0 |-> ##2 !IRQ[1])
		else $error("key request not dropped after capture write");
	a_read_lat: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		RD_STB && ADDR == 32'hff20_1000 |=> RD_DATA[31:16] == $past(RX_CHAR_COUNT))
		else $error("receive count misplaced");

endmodule : pil_irq_top

/* File: src/pil_pkg.sv */
package pil_pkg;

	// ----------------------------------------------------------------
	// Vectors and request line numbers
	// ----------------------------------------------------------------
	localparam logic [31:0] RESET_ADDR    = 32'h0000_0000;
	localparam logic [31:0] EXC_ADDR      = 32'h0000_0020;
	localparam int          IRQ_TMR0      = 0;
	localparam int          IRQ_KEY       = 1;
	localparam int          IRQ_TMR1      = 2;
	localparam int          IRQ_AUDIO     = 6;
	localparam int          IRQ_KBD       = 7;
	localparam int          IRQ_SER       = 8;
	localparam int          IRQ_IR        = 9;
	localparam int          IRQ_UART      = 10;
	localparam int          IRQ_EXP1      = 11;
	localparam int          IRQ_EXP2      = 12;
	localparam int          IRQ_KBD2      = 23;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [31:0] KEY_BASE      = 32'hff20_0000;
	localparam logic [31:0] EXP1_BASE     = 32'hff20_0010;
	localparam logic [31:0] EXP2_BASE     = 32'hff20_0020;
	localparam logic [31:0] PORT_DATA_OFS = 32'h0000_0000;
	localparam logic [31:0] PORT_MASK_OFS = 32'h0000_0008;
	localparam logic [31:0] PORT_EDGE_OFS = 32'h0000_000c;
	localparam logic [31:0] SER_DATA_ADDR = 32'hff20_1000;
	localparam logic [31:0] SER_CTRL_ADDR = 32'hff20_1004;
	localparam logic [31:0] TMR0_BASE     = 32'hff20_2000;
	localparam logic [31:0] TMR1_BASE     = 32'hff20_2020;
	localparam logic [31:0] TMR_STAT_OFS  = 32'h0000_0000;
	localparam logic [31:0] TMR_CTRL_OFS  = 32'h0000_0004;

	// ----------------------------------------------------------------
	// Field positions, widths, reset values
	// ----------------------------------------------------------------
	localparam int          KEY_W         = 4;
	localparam int          EXP_W         = 32;
	localparam int          CNT_LSB       = 16;
	localparam int          RVALID_BIT    = 15;
	localparam int          RX_EN_BIT     = 0;
	localparam int          TX_EN_BIT     = 1;
	localparam int          RX_PEND_BIT   = 8;
	localparam int          TX_PEND_BIT   = 9;
	localparam int          TMO_FLAG_BIT  = 0;
	localparam int          RUN_BIT       = 1;
	localparam int          TMO_IEN_BIT   = 0;
	localparam logic [15:0] SER_THRESH    = 16'h0007;
	localparam logic [15:0] RX_DEPTH      = 16'h0040;
	localparam logic [31:0] REG_RST       = 32'h0000_0000;

	// Register port request carrier
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} pil_req_t;

endpackage : pil_pkg

/* File: src/pil_port_edge.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Parallel port edge capture and mask
// ----------------------------------------------------------------
module pil_port_edge
	import pil_pkg::*;
#(
	parameter int N = 32
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [N-1:0] pins,
	input  wire logic         wr_mask,
	input  wire logic         wr_edge,
	input  wire logic [N-1:0] wdata,
	output logic      [N-1:0] mask_r,
	output logic      [N-1:0] edge_r,
	output logic              irq
);
	logic [N-1:0] prev_r;
	logic [N-1:0] rise;

	// Rising edge detect
	always_ff @(posedge clk) begin
		if (!rst_b) prev_r <= N'(REG_RST);
		else prev_r <= pins;
	end
	assign rise = pins & ~prev_r;

	// Mask register
	always_ff @(posedge clk) begin
		if (!rst_b) mask_r <= N'(REG_RST);
		else if (wr_mask) mask_r <= wdata;
	end

	// Capture; any write clears, new edge wins
	always_ff @(posedge clk) begin
		if (!rst_b) edge_r <= N'(REG_RST);
		else if (wr_edge) edge_r <= rise;
		else edge_r <= edge_r | rise;
	end

	assign irq = |(edge_r & mask_r);

	a_edge_set: assert property (@(posedge clk) disable iff (!rst_b)
		rise != '0 |=> (edge_r & $past(rise)) == $past(rise))
		else $error("edge capture missed a rising input");
	a_edge_clear: assert property (@(posedge clk) disable iff (!rst_b)
		wr_edge && rise == '0 |=> edge_r == '0 && !irq)
		else $error("edge capture not cleared by write");
endmodule : pil_port_edge

/* File: src/pil_tmr_irq.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Interval timer timeout flag and request
// ----------------------------------------------------------------
module pil_tmr_irq
	import pil_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic timeout,
	input  wire logic wr_stat,
	input  wire logic wr_ctrl,
	input  wire logic ien_wdata,
	output logic      flag_r,
	output logic      ien_r,
	output logic      irq
);
	// Timeout flag; any status write clears, new timeout wins
	always_ff @(posedge clk) begin
		if (!rst_b) flag_r <= 1'b0;
		else if (timeout) flag_r <= 1'b1;
		else if (wr_stat) flag_r <= 1'b0;
	end

	// Interrupt enable
	always_ff @(posedge clk) begin
		if (!rst_b) ien_r <= 1'b0;
		else if (wr_ctrl) ien_r <= ien_wdata;
	end

	assign irq = flag_r & ien_r;

	a_tmr_raise: assert property (@(posedge clk) disable iff (!rst_b)
		timeout && ien_r && !wr_ctrl |=> irq)
		else $error("timer request not raised on timeout");
	a_tmr_clear: assert property (@(posedge clk) disable iff (!rst_b)
		wr_stat && !timeout |=> !flag_r && !irq)
		else $error("timer request not cleared by status write");
	a_tmr_hold: assert property (@(posedge clk) disable iff (!rst_b)
		irq && !wr_stat && !wr_ctrl |=> irq)
		else $error("timer request dropped without clear");
endmodule : pil_tmr_irq

/* File: tb/pil_cpu_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Processor fetch model: follows reset and shared handler vectors
// ----------------------------------------------------------------
module pil_cpu_model
	import pil_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [31:0] irq,
	input  wire logic [31:0] reset_vector,
	input  wire logic [31:0] exc_vector,
	output logic      [31:0] fetch_addr_r
);
	// Fetch from reset vector, jump to handler on any request line
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			fetch_addr_r <= reset_vector;
		end else if (|irq) begin
			fetch_addr_r <= exc_vector;
		end
	end
endmodule : pil_cpu_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top
	import pil_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [31:0] addr = '0, wdata = '0, rd_data, irq, rst_vec, exc_vec, fetch_addr;
	logic        wr_stb = 1'b0, rd_stb = 1'b0, rx_pop, tx_push;
	logic [3:0]  key = '0;
	logic [31:0] exp_in[2] = '{32'h0, 32'h0};
	logic        tmr_tmo[2] = '{1'b0, 1'b0}, tmr_run[2] = '{1'b0, 1'b0};
	logic [15:0] rx_cnt = '0, tx_free = '0;
	logic [7:0]  rx_char = 8'h5a, tx_char;
	logic [4:0]  pt = '0;
	logic [31:0] d, base;
	int          fails = 0, n_compared = 0, cyc_cnt = 0;
	int          pt_line[5] = '{IRQ_AUDIO, IRQ_KBD, IRQ_IR, IRQ_UART, IRQ_KBD2};

	// Clock at 10 MHz
	always #50 ref_clk = ~ref_clk;

	pil_irq_top u_pil_irq_top (.REF_CLK(ref_clk), .RST_B(rst_b), .ADDR(addr),
		.WR_DATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data),
		.KEY_IN(key), .EXP1_IN(exp_in[0]), .EXP2_IN(exp_in[1]),
		.TMR0_TIMEOUT(tmr_tmo[0]), .TMR0_RUN(tmr_run[0]), .TMR1_TIMEOUT(tmr_tmo[1]),
		.TMR1_RUN(tmr_run[1]), .RX_CHAR_COUNT(rx_cnt), .RX_CHAR(rx_char),
		.TX_FREE_COUNT(tx_free), .RX_POP(rx_pop), .TX_PUSH(tx_push), .TX_CHAR(tx_char),
		.AUDIO_IRQ(pt[0]), .KBD_IRQ(pt[1]), .IR_IRQ(pt[2]), .UART_IRQ(pt[3]),
		.KBD2_IRQ(pt[4]), .IRQ(irq),
		.RESET_VECTOR(rst_vec), .EXC_VECTOR(exc_vec));

	pil_cpu_model u_pil_cpu_model (.clk(ref_clk), .rst_b(rst_b), .irq(irq),
		.reset_vector(rst_vec), .exc_vector(exc_vec), .fetch_addr_r(fetch_addr));

	// ----------------------------------------------------------------
	// Bus tasks and compare
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc

	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		addr   <= a;
		wdata  <= v;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
	endtask : wr

	task automatic rd(input logic [31:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		addr   <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		#1;
		v = rd_data;
	endtask : rd

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run

	// Hang guard
	always @(posedge ref_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			fails++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		cyc(8);
		rst_b <= 1'b1;
		cyc(2);
		chk("reset vector", 32'h0, rst_vec);
		chk("fetch after reset", 32'h0, fetch_addr);
		chk("handler vector", 32'h20, exc_vec);
		chk("lines idle", 32'h0, irq);
		// Pass-through lines one at a time
		for (int i = 0; i < 5; i++) begin
			pt <= 5'h1 << i;
			cyc(3);
			chk("pass line", 32'h1 << pt_line[i], irq);
		end
		pt <= '0;
		cyc(3);
		// Keys: masked and unmasked presses
		wr(KEY_BASE + PORT_MASK_OFS, 32'h5);
		rd(KEY_BASE + PORT_MASK_OFS, d);
		chk("key mask", 32'h5, d);
		key <= 4'h2;
		cyc(4);
		rd(KEY_BASE + PORT_EDGE_OFS, d);
		chk("key edge masked", 32'h2, d);
		chk("key line blocked", 32'h0, irq);
		key <= 4'h3;
		cyc(4);
		rd(KEY_BASE + PORT_EDGE_OFS, d);
		chk("key edge", 32'h3, d);
		chk("key line", 32'h1 << IRQ_KEY, irq);
		key <= 4'h0;
		cyc(4);
		chk("key line held", 32'h1 << IRQ_KEY, irq);
		chk("fetch handler", 32'h20, fetch_addr);
		wr(KEY_BASE + PORT_EDGE_OFS, 32'h0);
		cyc(3);
		chk("key line cleared", 32'h0, irq);
		rd(KEY_BASE + PORT_EDGE_OFS, d);
		chk("key edge cleared", 32'h0, d);
		// Expansion ports
		for (int p = 0; p < 2; p++) begin
			base = p ? EXP2_BASE : EXP1_BASE;
			wr(base + PORT_MASK_OFS, 32'h8000_0000);
			exp_in[p] <= 32'hc000_0000;
			cyc(4);
			rd(base + PORT_EDGE_OFS, d);
			chk("exp edge", 32'hc000_0000, d);
			chk("exp line", 32'h1 << (p ? IRQ_EXP2 : IRQ_EXP1), irq);
			wr(base + PORT_EDGE_OFS, 32'hffff_ffff);
			exp_in[p] <= 32'h0;
			cyc(3);
			chk("exp cleared", 32'h0, irq);
		end
		// Serial thresholds
		rx_cnt  <= 16'h7;
		tx_free <= 16'h7;
		wr(SER_CTRL_ADDR, 32'h3);
		cyc(3);
		rd(SER_CTRL_ADDR, d);
		chk("ser ctrl at 7", {16'h7, 14'h0, 2'b11}, d);
		chk("ser line at 7", 32'h0, irq);
		rx_cnt <= 16'h8;
		cyc(3);
		rd(SER_CTRL_ADDR, d);
		chk("ser rx pend", {16'h7, 6'h0, 2'b01, 6'h0, 2'b11}, d);
		chk("ser rx line", 32'h1 << IRQ_SER, irq);
		rd(SER_DATA_ADDR, d);
		chk("ser data", {16'h8, 1'b1, 7'h0, 8'h5a}, d);
		chk("rx pop", 32'h1, 32'(rx_pop));
		// Data write pushes one character to the transmit side
		wr(SER_DATA_ADDR, 32'h0000_0141);
		#1;
		chk("tx push", 32'h1, 32'(tx_push));
		chk("tx char", 32'h41, 32'(tx_char));
		rx_cnt <= 16'h7;
		cyc(3);
		chk("ser rx clear", 32'h0, irq);
		chk("rx pop ends", 32'h0, 32'(rx_pop));
		chk("tx push ends", 32'h0, 32'(tx_push));
		chk("read data idle", 32'h0, rd_data);
		wr(SER_CTRL_ADDR, 32'h1);
		tx_free <= 16'h8;
		cyc(3);
		rd(SER_CTRL_ADDR, d);
		chk("ser tx pend", {16'h8, 6'h0, 2'b10, 6'h0, 2'b01}, d);
		chk("ser tx disabled", 32'h0, irq);
		wr(SER_CTRL_ADDR, 32'h2);
		cyc(3);
		chk("ser tx line", 32'h1 << IRQ_SER, irq);
		tx_free <= 16'h7;
		cyc(3);
		chk("ser tx clear", 32'h0, irq);
		// Timers
		for (int t = 0; t < 2; t++) begin
			base = t ? TMR1_BASE : TMR0_BASE;
			wr(base + TMR_CTRL_OFS, 32'h1);
			tmr_run[t] <= 1'b1;
			@(posedge ref_clk);
			tmr_tmo[t] <= 1'b1;
			@(posedge ref_clk);
			tmr_tmo[t] <= 1'b0;
			cyc(3);
			rd(base + TMR_STAT_OFS, d);
			chk("tmr status", 32'h3, d);
			chk("tmr line", 32'h1 << (t ? IRQ_TMR1 : IRQ_TMR0), irq);
			wr(base + TMR_STAT_OFS, 32'hffff_ffff);
			cyc(3);
			rd(base + TMR_STAT_OFS, d);
			chk("tmr cleared", 32'h2, d);
			chk("tmr line cleared", 32'h0, irq);
			wr(base + TMR_CTRL_OFS, 32'h0);
			@(posedge ref_clk);
			tmr_tmo[t] <= 1'b1;
			@(posedge ref_clk);
			tmr_tmo[t] <= 1'b0;
			cyc(3);
			chk("tmr disabled", 32'h0, irq);
			wr(base + TMR_STAT_OFS, 32'h0);
			tmr_run[t] <= 1'b0;
		end
		// Unmapped place reads zero
		rd(32'hff20_0f00, d);
		chk("unmapped", 32'h0, d);
		complete_run();
	end
endmodule : tb_top
